// ### bench/cssts_src_model.sv
// Far-side event sources that pulse the capture channel's selectable events.
`timescale 1ns/10ps
module cssts_src_model
    import cssts_pkg::*;
#(
    parameter int CHAN_NUM = 1
) (
    // Clock and request, one bit per selector code
    input wire logic clk_i,
    input wire logic [31:0] fire_i,
    // Event outputs
    output logic [7:0] oc_evt_o,
    output logic [4:0] tmr_evt_o,
    output logic [7:0] cap_evt_o,
    output logic [2:0] cmp_evt_o,
    output logic adc_evt_o,
    output logic ctu_evt_o,
    output logic [CSSTS_SEQ_N-1:0] seq_evt_o
);
    logic [31:0] v_r = 32'h0;
    always @(posedge clk_i) begin
        v_r <= fire_i;
    end
    assign oc_evt_o = v_r[8:1];
    assign tmr_evt_o = v_r[15:11];
    assign cap_evt_o = v_r[23:16];
    assign cmp_evt_o = v_r[26:24];
    assign adc_evt_o = v_r[27];
    assign ctu_evt_o = v_r[28];
    // Bit 29 pulses the sequencer outputs of the other pairs, which must never reach us.
    always_comb begin
        seq_evt_o = {CSSTS_SEQ_N{v_r[29]}};
        seq_evt_o[(CHAN_NUM-1)%CSSTS_SEQ_N] = v_r[10];
    end
endmodule // cssts_src_model

// ### bench/cssts_sva.sv
// Checker of the capture sync and trigger source select block's port behaviour.
`timescale 1ns/10ps
module cssts_sva (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register bus
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Cascade and timer
    input wire logic partner_cascade_i,
    input wire logic cascade_o,
    input wire logic cascade_active_o,
    input wire logic [15:0] timer_o,
    input wire logic sync_pulse_o
);
    logic rd_dp_r;
    logic wr_dp_r;
    always_ff @(posedge clk_i) begin
        rd_dp_r <= rst_n_i && hsel_i && htrans_i[1] && hready_i && !hwrite_i;
        wr_dp_r <= rst_n_i && hsel_i && htrans_i[1] && hready_i && hwrite_i;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_ready;
        hreadyout_o == 1'b1;
    endproperty
    a_ready: assert property (p_ready) else $error("bus stalled");
    property p_okay;
        hresp_o == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("error response");
    property p_rd_idle;
        !rd_dp_r |-> hrdata_o == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
    property p_rd_hi;
        hrdata_o[31:16] == 16'h0;
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
    property p_sync_zero;
        sync_pulse_o |-> timer_o == 16'h0;
    endproperty
    a_sync_zero: assert property (p_sync_zero) else $error("sync left timer nonzero");
    property p_sync_once;
        sync_pulse_o |=> !sync_pulse_o;
    endproperty
    a_sync_once: assert property (p_sync_once) else $error("sync pulse too long");
    property p_casc;
        1'b1 |=> cascade_active_o == $past(cascade_o && partner_cascade_i);
    endproperty
    a_casc: assert property (p_casc) else $error("cascade pairing wrong");
    property p_step;
        !$past(wr_dp_r) && !sync_pulse_o |->
            timer_o == $past(timer_o) || timer_o == 16'($past(timer_o) + 16'h1);
    endproperty
    a_step: assert property (p_step) else $error("timer jumped");
endmodule // cssts_sva

bind cssts_top cssts_sva chk_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .partner_cascade_i(partner_cascade_i),
    .cascade_o(cascade_o), .cascade_active_o(cascade_active_o), .timer_o(timer_o),
    .sync_pulse_o(sync_pulse_o)
);

// ### bench/cssts_top_tb.sv
// Testbench for the capture sync and trigger source select block.
`timescale 1ns/10ps
module cssts_top_tb import cssts_pkg::*;;
    localparam int CHAN = 6;
    typedef struct packed {logic [31:0] ctl; logic [31:0] fire; logic [1:0] msk;
        logic [1:0] exp;} cssts_row_s;
    cssts_row_s rows [32];
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, pcasc = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, fire = 32'h0, hrdata, q;
    logic rdy, casc, casc_act, spulse, irq, adc, ctu;
    logic [7:0] oc, cap;
    logic [4:0] tmr;
    logic [2:0] cmp;
    logic [3:0] seq;
    logic [15:0] timer, t;
    logic [7:0] ofs [5] = '{CSSTS_OFS_CTRL, CSSTS_OFS_CTRL2, CSSTS_OFS_TIMER,
        CSSTS_OFS_STATUS, CSSTS_OFS_MASK};
    logic [1:0] e;
    int num_errors = 0;
    int total_checks = 0;
    always #20 clk_i = ~clk_i;
    cssts_top #(.CHAN_NUM(CHAN)) dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy),
        .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(), .oc_evt_i(oc), .tmr_evt_i(tmr),
        .cap_evt_i(cap), .cmp_evt_i(cmp), .adc_evt_i(adc), .ctu_evt_i(ctu), .seq_evt_i(seq),
        .partner_cascade_i(pcasc), .cascade_o(casc), .cascade_active_o(casc_act),
        .timer_o(timer), .sync_pulse_o(spulse), .irq_o(irq)
    );
    cssts_src_model #(.CHAN_NUM(CHAN)) src_u (
        .clk_i(clk_i), .fire_i(fire), .oc_evt_o(oc), .tmr_evt_o(tmr), .cap_evt_o(cap),
        .cmp_evt_o(cmp), .adc_evt_o(adc), .ctu_evt_o(ctu), .seq_evt_o(seq)
    );
    // ----
    // Tasks
    // ----
    task automatic report_and_stop;
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge clk_i);
        while (rdy !== 1'b1)
            @(posedge clk_i);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk_i);
        while (rdy !== 1'b1)
            @(posedge clk_i);
        q = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        chk(q & m, x);
    endtask
    task automatic pulse(input logic [31:0] m);
        fire <= m;
        @(posedge clk_i);
        fire <= 32'h0;
        repeat (3) @(posedge clk_i);
    endtask
    initial begin
        #(40 * 5000);
        num_errors++;
        report_and_stop();
    end
    // ----
    // Main sequence
    // ----
    initial begin
        for (int c = 0; c < 32; c++) begin
            e = (c == 0 || c == 9 || c > 28) ? 2'b00 : (c > 23 && c < 28) ? 2'b10 : 2'b01;
            rows[c] = '{{24'h0, e[1], 2'b00, 5'(c)}, e == 2'b00 ? 32'hffffffff : 32'h1 << c,
                e == 2'b00 ? 2'b11 : e, e};
        end
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        foreach (rows[i]) begin
            if (i == 16 + CHAN - 1) continue;
            bus(1'b1, CSSTS_OFS_CTRL2, rows[i].ctl);
            pulse(~(32'h1 << i));
            rd(CSSTS_OFS_STATUS, 32'h3, 32'h0);
            pulse(rows[i].fire);
            rd(CSSTS_OFS_STATUS, {30'h0, rows[i].msk}, {30'h0, rows[i].exp});
        end
        bus(1'b1, CSSTS_OFS_MASK, 32'h1);
        bus(1'b1, CSSTS_OFS_CTRL, 32'h1);
        bus(1'b1, CSSTS_OFS_CTRL2, 32'h2);
        repeat (6) @(posedge clk_i);
        chk(32'(timer !== 16'h0), 32'h1);
        fire <= 32'h4;
        @(posedge clk_i);
        fire <= 32'h0;
        repeat (8) begin
            @(posedge clk_i);
            if (spulse === 1'b1) break;
        end
        chk({31'h0, spulse}, 32'h1);
        chk({16'h0, timer}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        rd(CSSTS_OFS_STATUS, 32'h1, 32'h1);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, CSSTS_OFS_MASK, 32'h0);
        pulse(32'h4);
        chk({31'h0, irq}, 32'h0);
        rd(CSSTS_OFS_STATUS, 32'h1, 32'h1);
        // Trigger mode holds the timer until the source fires, then lets it run.
        bus(1'b1, CSSTS_OFS_CTRL2, 32'h81);
        bus(1'b1, CSSTS_OFS_TIMER, 32'h0);
        repeat (4) @(posedge clk_i);
        chk({16'h0, timer}, 32'h0);
        pulse(32'h2);
        rd(CSSTS_OFS_CTRL2, 32'h40, 32'h40);
        t = timer;
        repeat (4) @(posedge clk_i);
        chk({16'h0, timer}, {16'h0, 16'(t + 16'h4)});
        bus(1'b1, CSSTS_OFS_CTRL2, 32'h81);
        rd(CSSTS_OFS_CTRL2, 32'h40, 32'h0);
        t = timer;
        repeat (3) @(posedge clk_i);
        chk({16'h0, timer}, {16'h0, t});
        bus(1'b1, CSSTS_OFS_CTRL2, 32'h1c1);
        rd(CSSTS_OFS_CTRL2, 32'h1ff, 32'h1c1);
        repeat (2) @(posedge clk_i);
        chk({30'h0, casc, casc_act}, 32'h2);
        pcasc <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({30'h0, casc, casc_act}, 32'h3);
        bus(1'b1, 8'h14, 32'hffffffff);
        rd(8'h14, 32'hffffffff, 32'h0);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        chk({15'h0, irq, timer}, 32'h0);
        foreach (ofs[i])
            rd(ofs[i], 32'hffffffff, 32'h0);
        report_and_stop();
    end
endmodule // cssts_top_tb

// ### hw/cssts_pkg.sv
// Package of constants for the capture sync and trigger source select block.
// ---------------------------------------------------------------------------
// Operation
// R01 - Five-bit selector sits in control-two bits four:zero
// R02 - Codes 31,30,29,9,0 give no sync source
// R03 - Code 28 selects the charge-time unit trigger
// R04 - Code 27 selects converter one interrupt
// R05 - Codes 24-26 select comparators one to three
// R06 - Codes 16-23 select capture channels one to eight
// R07 - Codes 11-15 select general timers one to five
// R08 - Code 10 selects this channel's sequencer output
// R09 - Codes 1-8 select output compares one to eight
// R10 - Cascade needs both channels' cascade bits set
// R11 - Source sets trigger status; software reads/sets/clears
// R12 - Software never selects this channel as source
// R13 - Comparator/converter codes only for trigger operation; the code also accepts them as sync sources
// R14 - Sequencer outputs 8-11 feed channel pairs 1/5-4/8
// R15 - Sync clears timer; trigger holds then frees
// ---------------------------------------------------------------------------
package cssts_pkg;

    // -----------------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------------
    localparam logic [7:0] CSSTS_OFS_CTRL = 8'h00;
    localparam logic [7:0] CSSTS_OFS_CTRL2 = 8'h04;
    localparam logic [7:0] CSSTS_OFS_TIMER = 8'h08;
    localparam logic [7:0] CSSTS_OFS_STATUS = 8'h0c;
    localparam logic [7:0] CSSTS_OFS_MASK = 8'h10;

    // -----------------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------------
    localparam int CSSTS_CTRL_EN_BIT = 0;
    localparam int CSSTS_SEL_LSB = 0;
    localparam int CSSTS_SEL_W = 5;
    localparam int CSSTS_TRIGSTAT_BIT = 6;
    localparam int CSSTS_TRIGMODE_BIT = 7;
    localparam int CSSTS_CASC_BIT = 8;
    localparam int CSSTS_IRQ_W = 3;
    localparam int CSSTS_IRQ_SYNC_BIT = 0;
    localparam int CSSTS_IRQ_TRIG_BIT = 1;
    localparam int CSSTS_IRQ_WRAP_BIT = 2;
    localparam int CSSTS_TMR_W = 16;

    // -----------------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------------
    localparam logic [4:0] CSSTS_SEL_RST = 5'h00;
    localparam logic [2:0] CSSTS_MASK_RST = 3'h0;
    localparam logic [15:0] CSSTS_TMR_RST = 16'h0000;

    // -----------------------------------------------------------------------
    // Selector codes
    // -----------------------------------------------------------------------
    localparam logic [4:0] CSSTS_SEL_NONE0 = 5'h00;
    localparam logic [4:0] CSSTS_SEL_OC1 = 5'h01;
    localparam logic [4:0] CSSTS_SEL_OC8 = 5'h08;
    localparam logic [4:0] CSSTS_SEL_NONE9 = 5'h09;
    localparam logic [4:0] CSSTS_SEL_SEQ = 5'h0a;
    localparam logic [4:0] CSSTS_SEL_TMR1 = 5'h0b;
    localparam logic [4:0] CSSTS_SEL_TMR5 = 5'h0f;
    localparam logic [4:0] CSSTS_SEL_CAP1 = 5'h10;
    localparam logic [4:0] CSSTS_SEL_CAP8 = 5'h17;
    localparam logic [4:0] CSSTS_SEL_CMP1 = 5'h18;
    localparam logic [4:0] CSSTS_SEL_CMP3 = 5'h1a;
    localparam logic [4:0] CSSTS_SEL_ADC = 5'h1b;
    localparam logic [4:0] CSSTS_SEL_CTU = 5'h1c;

    // Sequencer outputs 8 to 11 serve channel pairs; index is channel minus one, mod four.
    localparam int CSSTS_SEQ_FIRST = 8;
    localparam int CSSTS_SEQ_N = 4;

endpackage

// ### hw/cssts_source_mux.sv
// Event source multiplexer for one capture channel's sync and trigger input.
`timescale 1ns/10ps
module cssts_source_mux
    import cssts_pkg::*;
#(
    parameter int CHAN_NUM = 1
) (
    // Selection
    input wire logic [4:0] sel_i,
    // Event sources
    input wire logic [7:0] oc_evt_i,
    input wire logic [4:0] tmr_evt_i,
    input wire logic [7:0] cap_evt_i,
    input wire logic [2:0] cmp_evt_i,
    input wire logic adc_evt_i,
    input wire logic ctu_evt_i,
    input wire logic [CSSTS_SEQ_N-1:0] seq_evt_i,
    // Result
    output logic evt_o,
    output logic sel_valid_o
);

    // -----------------------------------------------------------------------
    // Pick this channel's sequencer output
    // -----------------------------------------------------------------------
    localparam int SEQ_IDX = (CHAN_NUM - 1) % CSSTS_SEQ_N;
    logic seq_evt;
    assign seq_evt = seq_evt_i[SEQ_IDX]; // R14

    // -----------------------------------------------------------------------
    // Decode
    // -----------------------------------------------------------------------
    always_comb begin
        evt_o = 1'b0;
        sel_valid_o = 1'b1;
        if (sel_i >= CSSTS_SEL_OC1 && sel_i <= CSSTS_SEL_OC8) begin
            evt_o = oc_evt_i[3'(sel_i - CSSTS_SEL_OC1)]; // R09
        end else if (sel_i == CSSTS_SEL_SEQ) begin
            evt_o = seq_evt; // R08
        end else if (sel_i >= CSSTS_SEL_TMR1 && sel_i <= CSSTS_SEL_TMR5) begin
            evt_o = tmr_evt_i[3'(sel_i - CSSTS_SEL_TMR1)]; // R07
        end else if (sel_i >= CSSTS_SEL_CAP1 && sel_i <= CSSTS_SEL_CAP8) begin
            evt_o = cap_evt_i[3'(sel_i - CSSTS_SEL_CAP1)]; // R06
        end else if (sel_i >= CSSTS_SEL_CMP1 && sel_i <= CSSTS_SEL_CMP3) begin
            evt_o = cmp_evt_i[2'(sel_i - CSSTS_SEL_CMP1)]; // R05
        end else if (sel_i == CSSTS_SEL_ADC) begin
            evt_o = adc_evt_i; // R04
        end else if (sel_i == CSSTS_SEL_CTU) begin
            evt_o = ctu_evt_i; // R03
        end else begin
            sel_valid_o = 1'b0; // R02
        end
    end

endmodule // cssts_source_mux

// ### hw/cssts_top.sv
// Capture channel sync and trigger source select with its timer and AHB-Lite registers.
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
module cssts_top
    import cssts_pkg::*;
#(
    parameter int CHAN_NUM = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,

    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,

    // On-chip event sources, same clock
    input wire logic [7:0] oc_evt_i,
    input wire logic [4:0] tmr_evt_i,
    input wire logic [7:0] cap_evt_i,
    input wire logic [2:0] cmp_evt_i,
    input wire logic adc_evt_i,
    input wire logic ctu_evt_i,
    input wire logic [CSSTS_SEQ_N-1:0] seq_evt_i,

    // Cascade pairing with the partner channel
    input wire logic partner_cascade_i,
    output logic cascade_o,
    output logic cascade_active_o,

    // Capture timer and events
    output logic [15:0] timer_o,
    output logic sync_pulse_o,
    output logic irq_o
);

    // -----------------------------------------------------------------------
    // State
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic en;
        logic [4:0] sel;
        logic trig_stat;
        logic trig_mode;
        logic casc;
        logic casc_act;
        logic [15:0] tmr;
        logic src_prev;
        logic sync_pulse;
        logic [2:0] sts;
        logic [2:0] msk;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic irq;
    } cssts_state_s;

    cssts_state_s st_r;
    cssts_state_s st_nxt;

    // -----------------------------------------------------------------------
    // Source selection
    // -----------------------------------------------------------------------
    logic src_evt;
    logic src_valid;

    cssts_source_mux #(
        .CHAN_NUM(CHAN_NUM)
    ) u_mux (
        .sel_i(st_r.sel),
        .oc_evt_i(oc_evt_i),
        .tmr_evt_i(tmr_evt_i),
        .cap_evt_i(cap_evt_i),
        .cmp_evt_i(cmp_evt_i),
        .adc_evt_i(adc_evt_i),
        .ctu_evt_i(ctu_evt_i),
        .seq_evt_i(seq_evt_i),
        .evt_o(src_evt),
        .sel_valid_o(src_valid)
    );

    // -----------------------------------------------------------------------
    // Register read decode
    // -----------------------------------------------------------------------
    function automatic logic [31:0] read_word(input cssts_state_s s, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            CSSTS_OFS_CTRL: begin
                d[CSSTS_CTRL_EN_BIT] = s.en;
            end
            CSSTS_OFS_CTRL2: begin
                d[CSSTS_SEL_LSB +: CSSTS_SEL_W] = s.sel;
                d[CSSTS_TRIGSTAT_BIT] = s.trig_stat;
                d[CSSTS_TRIGMODE_BIT] = s.trig_mode;
                d[CSSTS_CASC_BIT] = s.casc;
            end
            CSSTS_OFS_TIMER: begin
                d[CSSTS_TMR_W-1:0] = s.tmr;
            end
            CSSTS_OFS_STATUS: begin
                d[CSSTS_IRQ_W-1:0] = s.sts;
            end
            CSSTS_OFS_MASK: begin
                d[CSSTS_IRQ_W-1:0] = s.msk;
            end
            default: begin
                d = 32'h0000_0000;
            end
        endcase
        return d;
    endfunction

    // -----------------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------------
    logic addr_phase;
    logic rd_req;
    logic wr_req;
    logic src_rise;
    logic hw_sync;
    logic hw_trig;
    logic run;
    logic wrap;
    logic [2:0] evt_set;
    logic [7:0] rd_addr;

    assign addr_phase = hsel_i && htrans_i[1] && hready_i;
    assign rd_req = addr_phase && !hwrite_i;
    assign wr_req = addr_phase && hwrite_i;
    assign rd_addr = {haddr_i[7:2], 2'b00};

    always_comb begin
        st_nxt = st_r;

        // Edge of the selected source; unsynchronized codes never fire.
        src_rise = src_valid && src_evt && !st_r.src_prev;
        hw_sync = src_rise && !st_r.trig_mode; // R15
        hw_trig = src_rise && st_r.trig_mode; // R15
        st_nxt.src_prev = src_valid && src_evt;

        // Write data phase: writes to all registers but status take effect here; a timer write is lost while the timer runs or a sync clears it.
        st_nxt.wr_pend = wr_req;
        st_nxt.wr_addr = {haddr_i[7:2], 2'b00};
        if (st_r.wr_pend) begin
            unique case (st_r.wr_addr)
                CSSTS_OFS_CTRL: begin
                    st_nxt.en = hwdata_i[CSSTS_CTRL_EN_BIT];
                end
                CSSTS_OFS_CTRL2: begin
                    st_nxt.sel = hwdata_i[CSSTS_SEL_LSB +: CSSTS_SEL_W]; // R01
                    st_nxt.trig_stat = hwdata_i[CSSTS_TRIGSTAT_BIT]; // R11
                    st_nxt.trig_mode = hwdata_i[CSSTS_TRIGMODE_BIT];
                    st_nxt.casc = hwdata_i[CSSTS_CASC_BIT];
                end
                CSSTS_OFS_TIMER: begin
                    st_nxt.tmr = hwdata_i[CSSTS_TMR_W-1:0];
                end
                CSSTS_OFS_MASK: begin
                    st_nxt.msk = hwdata_i[CSSTS_IRQ_W-1:0];
                end
                default: begin
                    st_nxt.wr_pend = wr_req;
                end
            endcase
        end

        // The source sets trigger status even if software clears it now.
        if (hw_trig) begin
            st_nxt.trig_stat = 1'b1; // R11
        end

        // Cascade takes effect only with both halves of the pair set.
        st_nxt.casc_act = st_r.casc && partner_cascade_i; // R10

        // Trigger operation holds the timer until the status is set.
        run = st_r.en && (!st_r.trig_mode || st_r.trig_stat); // R15
        wrap = 1'b0;
        if (hw_sync && st_r.en) begin
            st_nxt.tmr = CSSTS_TMR_RST; // R15
        end else if (run) begin
            st_nxt.tmr = st_r.tmr + 16'h0001;
            wrap = (st_r.tmr == 16'hffff);
        end
        // A disabled timer ignores sync, so no pulse may claim a clear that never happened.
        st_nxt.sync_pulse = hw_sync && st_r.en; // R15

        // Sticky status; a read clears, but an event in that cycle stays.
        evt_set = 3'h0;
        evt_set[CSSTS_IRQ_SYNC_BIT] = hw_sync;
        evt_set[CSSTS_IRQ_TRIG_BIT] = hw_trig;
        evt_set[CSSTS_IRQ_WRAP_BIT] = wrap;

        // Read data comes from the state with any pending write applied.
        st_nxt.rdata = 32'h0000_0000;
        if (rd_req) begin
            st_nxt.rdata = read_word(st_nxt, rd_addr);
        end
        if (rd_req && rd_addr == CSSTS_OFS_STATUS) begin
            st_nxt.sts = evt_set;
        end else begin
            st_nxt.sts = st_r.sts | evt_set;
        end
        st_nxt.irq = |(st_nxt.sts & st_nxt.msk);
    end

    // -----------------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_r.en <= 1'b0;
            st_r.sel <= CSSTS_SEL_RST;
            st_r.trig_stat <= 1'b0;
            st_r.trig_mode <= 1'b0;
            st_r.casc <= 1'b0;
            st_r.casc_act <= 1'b0;
            st_r.tmr <= CSSTS_TMR_RST;
            st_r.src_prev <= 1'b0;
            st_r.sync_pulse <= 1'b0;
            st_r.sts <= 3'h0;
            st_r.msk <= CSSTS_MASK_RST;
            st_r.wr_pend <= 1'b0;
            st_r.wr_addr <= 8'h00;
            st_r.rdata <= 32'h0000_0000;
            st_r.irq <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // -----------------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------------
    // The slave never stalls and never errors, so these are constant flops.
    logic ready_r;
    logic resp_r;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ready_r <= 1'b1;
            resp_r <= 1'b0;
        end else begin
            ready_r <= 1'b1;
            resp_r <= 1'b0;
        end
    end

    assign hrdata_o = st_r.rdata;
    assign hreadyout_o = ready_r;
    assign hresp_o = resp_r;
    assign cascade_o = st_r.casc;
    assign cascade_active_o = st_r.casc_act;
    assign timer_o = st_r.tmr;
    assign sync_pulse_o = st_r.sync_pulse;
    assign irq_o = st_r.irq;

endmodule // cssts_top
